// *** hw/capture_ctrl_pkg.sv ***
package capture_ctrl_pkg;
	// control-port word locations
	localparam logic [11:0] ADDR_IFACE_FIRST = 12'h800; // 2048
	localparam logic [11:0] ADDR_IFACE_LAST = 12'h807; // 2055
	localparam logic [11:0] ADDR_PIN_SETTING = 12'h808; // 2056
	localparam logic [11:0] ADDR_AUX_FIRST = 12'h809; // 2057
	localparam logic [11:0] ADDR_AUX_LAST = 12'h80c; // 2060
	localparam logic [11:0] ADDR_SAFE_DATA0 = 12'h810; // 2064
	localparam logic [11:0] ADDR_SAFE_ADDR0 = 12'h815; // 2069
	localparam logic [11:0] ADDR_CAPTURE_A = 12'h81a; // 2074
	localparam logic [11:0] ADDR_CAPTURE_B = 12'h81b; // 2075
	localparam logic [11:0] ADDR_CORE_CONTROL = 12'h81c; // 2076
	localparam int SAFE_SLOTS = 5;
	// capture setup word fields
	localparam int SETUP_STEP_LSB = 2;
	localparam int SETUP_STEP_W = 10;
	localparam int SETUP_SEL_LSB = 0;
	localparam int SETUP_SEL_W = 2;
	localparam logic [15:0] SETUP_MASK = 16'h0fff;
	// captured word: 5.23 internal, 5.19 presented
	localparam int CORE_W = 28;
	localparam int TRUNC_BITS = 4;
	localparam int CAPT_W = CORE_W - TRUNC_BITS;
	// core control fields
	localparam int CC_RATE_LSB = 0;
	localparam int CC_CORE_RUN_N = 2;
	localparam int CC_OUT_MUTE_N = 3;
	localparam int CC_IN_MUTE_N = 4;
	localparam int CC_SAFE_START = 5;
	localparam int CC_IFACE_OVR = 6;
	localparam int CC_PIN_OVR = 7;
	localparam int CC_AUX_OVR = 8;
	localparam int CC_DEBOUNCE_LSB = 12;
	localparam logic [15:0] CC_WRITE_MASK = 16'h31ff;
	localparam logic [15:0] CC_RESET = 16'h0000;
	// source selects
	localparam logic [1:0] SRC_MULT_X = 2'h0;
	localparam logic [1:0] SRC_MULT_Y = 2'h1;
	localparam logic [1:0] SRC_PRODUCT_SUM = 2'h2;
	localparam logic [1:0] SRC_SUM_FEEDBACK = 2'h3;
	// rate selects and instructions per sample
	localparam logic [1:0] RATE_1X = 2'h0;
	localparam logic [1:0] RATE_2X = 2'h1;
	localparam logic [1:0] RATE_4X = 2'h2;
	localparam logic [10:0] STEPS_1X = 11'd512;
	localparam logic [10:0] STEPS_2X = 11'd256;
	localparam logic [10:0] STEPS_4X = 11'd128;
	// debounce times and clock
	localparam int CLK_HZ = 20_000_000;
	localparam int DEB_MS_00 = 20;
	localparam int DEB_MS_01 = 40;
	localparam int DEB_MS_10 = 10;
	localparam int DEB_MS_11 = 5;
	localparam int DEB_CYC_00 = DEB_MS_00 * (CLK_HZ / 1000);
	localparam int DEB_CYC_01 = DEB_MS_01 * (CLK_HZ / 1000);
	localparam int DEB_CYC_10 = DEB_MS_10 * (CLK_HZ / 1000);
	localparam int DEB_CYC_11 = DEB_MS_11 * (CLK_HZ / 1000);
	typedef enum logic [1:0] {SL_IDLE, SL_WAIT, SL_MOVE} safe_state_t;
endpackage

// *** hw/capture_channel_unit.sv ***
// one capture channel: setup word plus latched 5.19 value
module capture_channel_unit
	import capture_ctrl_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic reset_n, // synchronous, active low
	input wire logic setup_we, // write of setup word
	input wire logic [15:0] setup_wdata, // setup word
	input wire logic [9:0] pc, // program counter
	input wire logic step_valid, // pc names a live step
	input wire logic [CORE_W-1:0] src_x, // multiplier x operand
	input wire logic [CORE_W-1:0] src_y, // multiplier y operand
	input wire logic [CORE_W-1:0] src_mac, // product sum result
	input wire logic [CORE_W-1:0] src_fb, // sum feedback path
	output logic [CAPT_W-1:0] value_q // captured value
);
	logic [9:0] step_q;
	logic [1:0] sel_q;
	logic [CORE_W-1:0] pick;

	// setup word store
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			step_q <= '0;
			sel_q <= '0;
		end else if (setup_we) begin
			step_q <= setup_wdata[SETUP_STEP_LSB +: SETUP_STEP_W];
			sel_q <= setup_wdata[SETUP_SEL_LSB +: SETUP_SEL_W];
		end
	end

	// source mux
	always_comb begin
		unique case (sel_q)
			SRC_MULT_X: pick = src_x;
			SRC_MULT_Y: pick = src_y;
			SRC_PRODUCT_SUM: pick = src_mac;
			SRC_SUM_FEEDBACK: pick = src_fb;
		endcase
	end

	// latch at matching step, hold otherwise
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			value_q <= '0;
		end else if (step_valid && pc == step_q) begin
			value_q <= pick[CORE_W-1:TRUNC_BITS];
		end
	end

	property p_capture_hold;
		@(posedge clk) disable iff (!reset_n)
			!(step_valid && pc == step_q) |=> $stable(value_q);
	endproperty
	a_capture_hold: assert property (p_capture_hold) else $error("capture changed off step");

	property p_capture_take;
		@(posedge clk) disable iff (!reset_n)
			(step_valid && pc == step_q) |=> value_q == $past(pick[CORE_W-1:TRUNC_BITS]);
	endproperty
	a_capture_take: assert property (p_capture_take) else $error("capture value wrong");

	property p_sel_mux;
		@(posedge clk) disable iff (!reset_n)
			sel_q == SRC_PRODUCT_SUM |-> pick == src_mac;
	endproperty
	a_sel_mux: assert property (p_sel_mux) else $error("source select wrong");
endmodule

// *** hw/capture_core_control.sv ***
// Behaviour
// - each channel holds a step index 0..1023 for its capture point
// - on pc matching the step, selected core register is copied to capture
// - capture drops four low bits of 5.23 word giving 5.19
// - setup word: step in bits 11:2, select in 1:0, 15:12 zero
// - capture channels read at locations 2074 and 2075
// - select 00 x operand, 01 y operand, 10 product sum, 11 feedback
// - debounce select gives 20, 40, 10 or 5 ms
// - aux override lets port write aux registers, pins ignored
// - pin override makes pin setting register take port writes
// - interface override lets port write interface regs, program blocked
// - writing start begins safeload; bit clears itself when done unless core control is written in that same cycle
// - safeload moves only slots written since previous safeload
// - input mute is active low, reset zero, muted until set
// - output mute is active low, reset zero, muted until set
// - core run active high, reset zero clears core state
// - rate select gives 512, 256, 128 steps; 11 reserved
// - safeload waits for the next frame pulse after start, then steps through its five slots in the five cycles that follow, moving the written ones
module capture_core_control
	import capture_ctrl_pkg::*;
#(
	parameter int CYC_PER_MS = CLK_HZ / 1000 // core clock cycles per millisecond
)
(
	input wire logic clk, // core clock 20 MHz
	input wire logic reset_n, // synchronous, active low
	input wire logic wr_en, // control-port write strobe
	input wire logic rd_en, // control-port read strobe
	input wire logic [11:0] addr, // control-port word location
	input wire logic [15:0] wdata, // write data
	input wire logic [9:0] pc, // core program counter
	input wire logic frame_start, // one-cycle pulse per sample frame
	input wire logic [CORE_W-1:0] src_x, // multiplier x operand
	input wire logic [CORE_W-1:0] src_y, // multiplier y operand
	input wire logic [CORE_W-1:0] src_mac, // product sum result
	input wire logic [CORE_W-1:0] src_fb, // sum feedback path
	input wire logic gpio_in, // raw multipurpose pin, async
	output logic [15:0] rdata_q, // read data
	output logic rvalid_q, // read data valid pulse
	output logic [1:0] rate_select_q, // rate select
	output logic [10:0] steps_per_sample_q, // instructions per sample
	output logic core_run_n_q, // 1 lets core run
	output logic core_clear_q, // core state held cleared
	output logic input_mute_n_q, // 1 passes input audio
	output logic output_mute_n_q, // 1 passes output audio
	output logic aux_converter_override_q, // port owns aux registers
	output logic pin_setting_override_q, // port owns pin setting register
	output logic interface_override_q, // port owns interface registers
	output logic program_iface_we_allow_q, // program may update interface regs
	output logic port_iface_we_q, // accepted port write to interface reg
	output logic port_aux_we_q, // accepted port write to aux reg
	output logic port_pin_we_q, // accepted port write to pin setting
	output logic pin_from_gpio_q, // pin setting follows pins
	output logic gpio_debounced_q, // debounced gpio level
	output logic safe_move_q, // one-cycle move of a safeload slot
	output logic [2:0] safe_slot_q // slot being moved
);
	logic [15:0] ctrl_q;
	logic [SAFE_SLOTS-1:0] dirty_q;
	logic [CAPT_W-1:0] cap_a, cap_b;
	logic [2:0] slot_q;
	logic step_ok;
	safe_state_t sl_q;
	logic g1_q, g2_q;
	logic [20:0] deb_cnt_q, deb_lim;

	assign step_ok = ({1'b0, pc} < steps_per_sample_q);

	// debounce counter is 21 bits: the longest time must fit in it
	if (CYC_PER_MS < 1 || DEB_MS_01 * CYC_PER_MS > 21'h1fffff) begin : g_bad_rate
		$error("debounce count does not fit its counter");
	end

	capture_channel_unit u_cap_a (
		.clk(clk), .reset_n(reset_n),
		.setup_we(wr_en && addr == ADDR_CAPTURE_A), .setup_wdata(wdata & SETUP_MASK),
		.pc(pc), .step_valid(step_ok),
		.src_x(src_x), .src_y(src_y), .src_mac(src_mac), .src_fb(src_fb),
		.value_q(cap_a)
	);
	capture_channel_unit u_cap_b (
		.clk(clk), .reset_n(reset_n),
		.setup_we(wr_en && addr == ADDR_CAPTURE_B), .setup_wdata(wdata & SETUP_MASK),
		.pc(pc), .step_valid(step_ok),
		.src_x(src_x), .src_y(src_y), .src_mac(src_mac), .src_fb(src_fb),
		.value_q(cap_b)
	);

	// core control register; start bit cleared by hardware
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_q <= CC_RESET;
		end else if (wr_en && addr == ADDR_CORE_CONTROL) begin
			ctrl_q <= wdata & CC_WRITE_MASK;
			if (!wdata[CC_SAFE_START] && ctrl_q[CC_SAFE_START])
				ctrl_q[CC_SAFE_START] <= 1'b1; // start stays until done
		end else if (sl_q == SL_MOVE && slot_q == 3'(SAFE_SLOTS - 1)) begin
			ctrl_q[CC_SAFE_START] <= 1'b0;
		end
	end

	// read port: 24-bit capture shown as upper 16 bits of 5.19 word
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdata_q <= '0;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= rd_en;
			unique case (addr)
				ADDR_CAPTURE_A: rdata_q <= cap_a[CAPT_W-1 -: 16];
				ADDR_CAPTURE_B: rdata_q <= cap_b[CAPT_W-1 -: 16];
				ADDR_CORE_CONTROL: rdata_q <= ctrl_q;
				default: rdata_q <= '0;
			endcase
		end
	end

	// decoded control outputs
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rate_select_q <= RATE_1X;
			steps_per_sample_q <= STEPS_1X;
			core_run_n_q <= 1'b0;
			core_clear_q <= 1'b1;
			input_mute_n_q <= 1'b0;
			output_mute_n_q <= 1'b0;
			aux_converter_override_q <= 1'b0;
			pin_setting_override_q <= 1'b0;
			interface_override_q <= 1'b0;
			program_iface_we_allow_q <= 1'b1;
			pin_from_gpio_q <= 1'b1;
		end else begin
			rate_select_q <= ctrl_q[CC_RATE_LSB +: 2];
			unique case (ctrl_q[CC_RATE_LSB +: 2])
				RATE_1X: steps_per_sample_q <= STEPS_1X;
				RATE_2X: steps_per_sample_q <= STEPS_2X;
				RATE_4X: steps_per_sample_q <= STEPS_4X;
				default: steps_per_sample_q <= STEPS_1X; // reserved code
			endcase
			core_run_n_q <= ctrl_q[CC_CORE_RUN_N];
			core_clear_q <= !ctrl_q[CC_CORE_RUN_N];
			input_mute_n_q <= ctrl_q[CC_IN_MUTE_N];
			output_mute_n_q <= ctrl_q[CC_OUT_MUTE_N];
			aux_converter_override_q <= ctrl_q[CC_AUX_OVR];
			pin_setting_override_q <= ctrl_q[CC_PIN_OVR];
			interface_override_q <= ctrl_q[CC_IFACE_OVR];
			program_iface_we_allow_q <= !ctrl_q[CC_IFACE_OVR];
			pin_from_gpio_q <= !ctrl_q[CC_PIN_OVR];
		end
	end

	// port write qualification for override-owned registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			port_iface_we_q <= 1'b0;
			port_aux_we_q <= 1'b0;
			port_pin_we_q <= 1'b0;
		end else begin
			port_iface_we_q <= wr_en && ctrl_q[CC_IFACE_OVR] &&
				addr >= ADDR_IFACE_FIRST && addr <= ADDR_IFACE_LAST;
			port_aux_we_q <= wr_en && ctrl_q[CC_AUX_OVR] &&
				addr >= ADDR_AUX_FIRST && addr <= ADDR_AUX_LAST;
			port_pin_we_q <= wr_en && ctrl_q[CC_PIN_OVR] && addr == ADDR_PIN_SETTING;
		end
	end

	// safeload: mark written slots, move them at next frame
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dirty_q <= '0;
			slot_q <= '0;
			sl_q <= SL_IDLE;
			safe_move_q <= 1'b0;
			safe_slot_q <= '0;
		end else begin
			safe_move_q <= 1'b0;
			for (int i = 0; i < SAFE_SLOTS; i++) begin
				if (sl_q == SL_MOVE && slot_q == 3'(i))
					dirty_q[i] <= 1'b0;
				if (wr_en && (addr == ADDR_SAFE_DATA0 + 12'(i) ||
					addr == ADDR_SAFE_ADDR0 + 12'(i)))
					dirty_q[i] <= 1'b1; // write wins over clear
			end
			unique case (sl_q)
				SL_IDLE: if (ctrl_q[CC_SAFE_START]) sl_q <= SL_WAIT;
				SL_WAIT: if (frame_start) begin
					sl_q <= SL_MOVE;
					slot_q <= '0;
				end
				SL_MOVE: begin
					safe_move_q <= dirty_q[slot_q];
					safe_slot_q <= slot_q;
					if (slot_q == 3'(SAFE_SLOTS - 1)) sl_q <= SL_IDLE;
					else slot_q <= slot_q + 3'h1;
				end
			endcase
		end
	end

	// pin synchroniser and debounce
	always_comb begin
		unique case (ctrl_q[CC_DEBOUNCE_LSB +: 2])
			2'h0: deb_lim = 21'(DEB_MS_00 * CYC_PER_MS);
			2'h1: deb_lim = 21'(DEB_MS_01 * CYC_PER_MS);
			2'h2: deb_lim = 21'(DEB_MS_10 * CYC_PER_MS);
			2'h3: deb_lim = 21'(DEB_MS_11 * CYC_PER_MS);
		endcase
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			g1_q <= 1'b0;
			g2_q <= 1'b0;
			deb_cnt_q <= '0;
			gpio_debounced_q <= 1'b0;
		end else begin
			g1_q <= gpio_in;
			g2_q <= g1_q;
			if (g2_q == gpio_debounced_q) deb_cnt_q <= '0;
			else if (deb_cnt_q >= deb_lim - 21'h1) begin
				gpio_debounced_q <= g2_q;
				deb_cnt_q <= '0;
			end else deb_cnt_q <= deb_cnt_q + 21'h1;
		end
	end

	property p_start_clears;
		@(posedge clk) disable iff (!reset_n)
			(sl_q == SL_MOVE && slot_q == 3'(SAFE_SLOTS - 1) && !wr_en) |=> !ctrl_q[CC_SAFE_START];
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("start bit not cleared");

	property p_move_dirty;
		@(posedge clk) disable iff (!reset_n)
			safe_move_q |-> $past(dirty_q[slot_q]);
	endproperty
	a_move_dirty: assert property (p_move_dirty) else $error("clean slot moved");

	property p_frame_bound;
		@(posedge clk) disable iff (!reset_n)
			(sl_q == SL_WAIT && frame_start) |=> sl_q == SL_MOVE ##4 sl_q == SL_MOVE ##1 sl_q == SL_IDLE;
	endproperty
	a_frame_bound: assert property (p_frame_bound) else $error("safeload overran frame");

	property p_mutes;
		@(posedge clk) disable iff (!reset_n)
			1'b1 |=> input_mute_n_q == $past(ctrl_q[CC_IN_MUTE_N]) &&
				output_mute_n_q == $past(ctrl_q[CC_OUT_MUTE_N]);
	endproperty
	a_mutes: assert property (p_mutes) else $error("mute mismatch");

	property p_run_clear;
		@(posedge clk) disable iff (!reset_n)
			core_clear_q != core_run_n_q;
	endproperty
	a_run_clear: assert property (p_run_clear) else $error("run and clear disagree");

	property p_rate;
		@(posedge clk) disable iff (!reset_n)
			rate_select_q == RATE_4X |=> steps_per_sample_q == STEPS_4X || rate_select_q != RATE_4X;
	endproperty
	a_rate: assert property (p_rate) else $error("rate steps wrong");

	property p_iface_block;
		@(posedge clk) disable iff (!reset_n)
			interface_override_q |-> !program_iface_we_allow_q;
	endproperty
	a_iface_block: assert property (p_iface_block) else $error("program not blocked");

	property p_pin_ovr;
		@(posedge clk) disable iff (!reset_n)
			port_pin_we_q |-> $past(ctrl_q[CC_PIN_OVR]);
	endproperty
	a_pin_ovr: assert property (p_pin_ovr) else $error("pin write without override");
endmodule

// *** tb/control_host_model.sv ***
// host side of the control port: one word per strobe, driven at the falling edge
module control_host_model
	import capture_ctrl_pkg::*;
(
	input wire logic clk, // core clock
	output logic wr_en, // write strobe
	output logic rd_en, // read strobe
	output logic [11:0] addr, // word location
	output logic [15:0] wdata, // write data
	input wire logic [15:0] rdata_q, // read data
	input wire logic rvalid_q // read data valid pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle port at time zero
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 12'h000;
		wdata = 16'h0000;
	end
	// setup word: step index in 11:2, source select in 1:0, top bits zero
	function automatic logic [15:0] setup_word(input logic [9:0] step, input logic [1:0] sel);
		return {4'h0, step, sel};
	endfunction
	// request held across the taking edge, dropped at the next falling edge
	task automatic write_word(input logic [11:0] a, input logic [15:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(posedge clk);
		@(negedge clk);
		wr_en = 1'b0;
		wdata = ~d; // stale data is not left on the lines
	endtask
	// answer is taken one cycle after the strobe, before the location moves
	task automatic read_word(input logic [11:0] a, output logic [15:0] d, output logic v);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(posedge clk);
		@(negedge clk);
		d = rdata_q;
		v = rvalid_q;
		rd_en = 1'b0;
	endtask
endmodule

// *** tb/tb_dsp_capture_and_core_control.sv ***
// register-level tests of capture channels and core control
module tb_dsp_capture_and_core_control;
	import capture_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset_n, frame_start, gpio_in, wr_en, rd_en, rvalid_q, run_n, clr, imute_n, omute_n;
	logic aux_ovr, pin_ovr, if_ovr, prog_allow, ifw, axw, pnw, pin_gpio, deb, smove;
	logic [11:0] addr;
	logic [15:0] wdata, rdata_q, rd;
	logic [9:0] pc;
	logic [27:0] src [4];
	logic [1:0] rsel;
	logic [10:0] steps;
	logic [2:0] sslot;
	logic [4:0] mask;
	logic v;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [11:0] alist [5] = '{ADDR_IFACE_FIRST, ADDR_IFACE_LAST, ADDR_PIN_SETTING,
		ADDR_AUX_FIRST, ADDR_AUX_LAST};
	logic [2:0] plist [5] = '{3'b100, 3'b100, 3'b010, 3'b001, 3'b001};
	logic [10:0] stab [4] = '{STEPS_1X, STEPS_2X, STEPS_4X, STEPS_1X};
	// clock
	always #25 clk = ~clk;
	// two cycles per millisecond keeps the debounce times short enough to run
	capture_core_control #(.CYC_PER_MS(2)) dut (.clk(clk), .reset_n(reset_n), .wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr), .wdata(wdata), .pc(pc), .frame_start(frame_start), .src_x(src[0]),
		.src_y(src[1]), .src_mac(src[2]), .src_fb(src[3]), .gpio_in(gpio_in),
		.rdata_q(rdata_q), .rvalid_q(rvalid_q), .rate_select_q(rsel),
		.steps_per_sample_q(steps), .core_run_n_q(run_n), .core_clear_q(clr),
		.input_mute_n_q(imute_n), .output_mute_n_q(omute_n),
		.aux_converter_override_q(aux_ovr), .pin_setting_override_q(pin_ovr),
		.interface_override_q(if_ovr), .program_iface_we_allow_q(prog_allow),
		.port_iface_we_q(ifw), .port_aux_we_q(axw), .port_pin_we_q(pnw),
		.pin_from_gpio_q(pin_gpio), .gpio_debounced_q(deb), .safe_move_q(smove),
		.safe_slot_q(sslot));
	control_host_model host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .rdata_q(rdata_q), .rvalid_q(rvalid_q));
	// comparison with counting
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// read a word and compare data and valid pulse
	task automatic rd_check(input logic [11:0] a, input logic [15:0] exp);
		host.read_word(a, rd, v);
		check("read valid", 1, v);
		check($sformatf("read %h", a), exp, rd);
	endtask
	// run the program counter over steps 0..7, then park it beyond the frame
	task automatic sweep();
		for (int p = 0; p < 8; p++) begin
			@(negedge clk);
			pc = p;
		end
		@(negedge clk);
		pc = 10'd600;
		repeat (2) @(negedge clk);
	endtask
	// start a safeload, give one frame pulse, collect the slots moved
	task automatic safeload_round(input logic [4:0] exp);
		host.write_word(ADDR_CORE_CONTROL, 16'h003c);
		mask = 5'b00000;
		for (int i = 0; i < 30; i++) begin
			@(negedge clk);
			if (smove === 1'b1) begin
				mask[sslot] = 1'b1;
			end
			frame_start = (i == 3);
		end
		check("moved slots", exp, mask);
		rd_check(ADDR_CORE_CONTROL, 16'h001c);
	endtask
	// verdict
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	// main sequence
	initial begin
		reset_n = 1'b0;
		frame_start = 1'b0;
		gpio_in = 1'b0;
		pc = 10'd600;
		src = '{28'h1234567, 28'h89abcde, 28'h5a5a5a5, 28'hfedcba9};
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		check("reset outs", 7'b0001110, {run_n, imute_n, omute_n, clr, prog_allow, pin_gpio, deb});
		check("reset steps", 512, steps);
		rd_check(ADDR_CORE_CONTROL, 16'h0000);
		rd_check(ADDR_CAPTURE_A, 16'h0000);
		rd_check(ADDR_CAPTURE_B, 16'h0000);
		rd_check(12'h81d, 16'h0000);
		// every rate and debounce code, with run and both mutes released
		for (int r = 0; r < 4; r++) begin
			host.write_word(ADDR_CORE_CONTROL, 16'h001c | (r << 12) | r);
			rd_check(ADDR_CORE_CONTROL, 16'h001c | (r << 12) | r);
			repeat (2) @(negedge clk);
			check("rate", {r[1:0], stab[r]}, {rsel, steps});
			check("run mutes", 4'b1110, {run_n, imute_n, omute_n, clr});
		end
		// debounce select is now 11: 5 ms, ten cycles here, after two sync flops
		gpio_in = 1'b1;
		repeat (8) @(negedge clk);
		check("debounce early", 0, deb);
		repeat (8) @(negedge clk);
		check("debounce late", 1, deb);
		// overrides on, then off: port writes accepted only while owned
		for (int on = 1; on >= 0; on--) begin
			host.write_word(ADDR_CORE_CONTROL, on ? 16'hffdf : 16'h001c);
			repeat (2) @(negedge clk);
			check("owners", on ? 5'b11100 : 5'b00011, {if_ovr, pin_ovr, aux_ovr, prog_allow, pin_gpio});
			for (int k = 0; k < 5; k++) begin
				host.write_word(alist[k], 16'h0001);
				check("port write", on ? plist[k] : 3'b000, {ifw, pnw, axw});
			end
		end
		rd_check(ADDR_CORE_CONTROL, 16'h001c);
		// every source on both channels, channel b at step zero
		for (int s = 0; s < 4; s++) begin
			host.write_word(ADDR_CAPTURE_A, host.setup_word(10'd5, 2'(s)));
			host.write_word(ADDR_CAPTURE_B, host.setup_word(10'd0, 2'(3 - s)));
			sweep();
			rd_check(ADDR_CAPTURE_A, src[s][27:12]);
			rd_check(ADDR_CAPTURE_B, src[3-s][27:12]);
		end
		// sources move but no step matches: captured words must stand
		src = '{28'h0f0f0f0, 28'h0f0f0f0, 28'h0f0f0f0, 28'h0f0f0f0};
		for (int p = 1; p < 5; p++) begin
			@(negedge clk);
			pc = p;
		end
		@(negedge clk);
		pc = 10'd600;
		rd_check(ADDR_CAPTURE_A, 16'hfedc);
		rd_check(ADDR_CAPTURE_A, 16'hfedc);
		rd_check(ADDR_CAPTURE_B, 16'h1234);
		// safeload with slots 0 and 2 dirty only, then slot 4 only
		host.write_word(ADDR_SAFE_DATA0, 16'h0abc);
		host.write_word(ADDR_SAFE_ADDR0 + 12'h2, 16'h0012);
		safeload_round(5'b00101);
		host.write_word(ADDR_SAFE_DATA0 + 12'h4, 16'h0345);
		safeload_round(5'b10000);
		tally_and_finish();
	end
endmodule
